/* File: rtl/ppp_defs.svh */
/*
 * Constants of the parallel programming port: command codes, action codes,
 * page geometry, fuse reset values and timing counts.
 * Included from ppp_pkg, ppp_port and the bench; the guard defines each macro once.
 */
// Notes on behaviour
// - Flash pages are 64 words, low six bits index word
// - EEPROM pages are four bytes, 128 pages
// - Load pulse acts on the two action bits
// - Decode chip erase, fuse, lock, flash, EEPROM writes
// - Decode signature, fuse/lock, flash, EEPROM reads
// - Write strobe runs a loaded write command only
// - Ready flag low while programming or erasing
// - Drive data bus only while output enable low
// - Byte selects choose low, high or extended byte
// - Command and address persist across operations
// - Address high byte stays latched until reloaded
// - Erase clears memories, lock last, fuses kept
// - Keep fuse programmed preserves EEPROM on erase
// - Erase starts on write strobe, busy until done
// - Flash page is collected then programmed whole
// - Page latch strobe moves data into page buffer
// - All-zero command is no-op, ends page writes
`ifndef PPP_DEFS_SVH
`define PPP_DEFS_SVH

//------------------------------------------------------------
// Command bytes
//------------------------------------------------------------
`define PPP_CMD_NOP     8'h00
`define PPP_CMD_ERASE   8'h80
`define PPP_CMD_WFUSE   8'h40
`define PPP_CMD_WLOCK   8'h20
`define PPP_CMD_WFLASH  8'h10
`define PPP_CMD_WEE     8'h11
`define PPP_CMD_RSIG    8'h08
`define PPP_CMD_RFUSE   8'h04
`define PPP_CMD_RFLASH  8'h02
`define PPP_CMD_REE     8'h03

//------------------------------------------------------------
// Action codes on the load pulse
//------------------------------------------------------------
`define PPP_XA_ADDR     2'h0
`define PPP_XA_DATA     2'h1
`define PPP_XA_CMD      2'h2
`define PPP_XA_IDLE     2'h3

//------------------------------------------------------------
// Geometry and fuse layout
//------------------------------------------------------------
`define PPP_FLASH_PAGE_BITS 6
`define PPP_EE_PAGE_BITS    2
`define PPP_EE_AW           9
`define PPP_FUSE_LO_RST     8'h62
`define PPP_FUSE_HI_RST     8'hdf
`define PPP_FUSE_EXT_RST    8'hff
`define PPP_LOCK_RST        8'hff
`define PPP_FUSE_KEEP_BIT   3
`define PPP_ERASED_WORD     16'hffff
`define PPP_ERASED_BYTE     8'hff

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define PPP_CLK_PERIOD_NS   25
`define PPP_T_ENTRY_NS      100
`define PPP_ENTRY_CYC  ((`PPP_T_ENTRY_NS + `PPP_CLK_PERIOD_NS - 1) / `PPP_CLK_PERIOD_NS)
`define PPP_T_PULSE_NS      250
`define PPP_PULSE_CYC       (`PPP_T_PULSE_NS / `PPP_CLK_PERIOD_NS)
`define PPP_MIN_TOGGLES     6

`endif

/* File: rtl/ppp_pkg.sv */
/*
 * Types of the parallel programming port: pin bundle, buffer item,
 * entry and operation enums, and the state record of the port.
 * Assumes ppp_defs.svh on the include path.
 */
package ppp_pkg;
	`include "ppp_defs.svh"

	//------------------------------------------------------------
	// Pins as seen from the programmer
	//------------------------------------------------------------
	typedef struct packed {
		logic       hv_reset;          // High voltage present on reset pin
		logic       load_pulse_input;  // Load clock pin
		logic       oe_n;              // Output enable, active low
		logic       wr_n;              // Write strobe, active low
		logic       page_latch_strobe; // Also first byte select
		logic       xtal_action_bit1;  // Also extended byte select
		logic       xtal_action_bit0;  // Action bit 0
		logic [7:0] data;              // Data bus input side
	} ppp_pins_s;

	// Word moved into a page buffer
	typedef struct packed {
		logic        to_ee;
		logic [5:0]  idx;
		logic [15:0] word;
	} ppp_item_s;

	// Programming mode entry
	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_ARM    = 2'b01,
		MODE_ACTIVE = 2'b10,
		MODE_FAIL   = 2'b11
	} ppp_mode_e;

	// Operation in progress
	typedef enum logic [2:0] {
		OP_NONE     = 3'b000,
		OP_ERASE    = 3'b001,
		OP_FLASH    = 3'b010,
		OP_EE       = 3'b011,
		OP_FUSE_LO  = 3'b100,
		OP_FUSE_HI  = 3'b101,
		OP_FUSE_EXT = 3'b110,
		OP_LOCK     = 3'b111
	} ppp_op_e;

	// State of the port, memories and buffers aside
	typedef struct packed {
		ppp_pins_s  sync1;
		ppp_pins_s  sync2;
		ppp_pins_s  prev;
		ppp_mode_e  mode;
		logic [2:0] toggles;
		logic [2:0] entry_cnt;
		logic [7:0] cmd;
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
		logic [7:0] data_lo;
		logic [7:0] data_hi;
		logic       busy;
		ppp_op_e    op;
		logic [15:0] cnt;
		logic       latch_pend;
		logic [7:0] fuse_lo;
		logic [7:0] fuse_hi;
		logic [7:0] fuse_ext;
		logic [7:0] lock;
		logic [7:0] dout;
		logic       doe;
		logic       rdy;
		logic       act;
	} ppp_state_s;
endpackage : ppp_pkg

/* File: rtl/ppp_buffer.sv */
/*
 * Small FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ppp_buffer #(
	parameter int W     = 23,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem; // Entries
		logic [AW-1:0]           wp;  // Write pointer
		logic [AW-1:0]           rp;  // Read pointer
		logic [AW:0]             cnt; // Fill level
	} ppp_buf_s;

	ppp_buf_s s_q, s_d;
	logic     push, pop;

	// Honest full and empty flags
	assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = s_q.mem[s_q.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Next state
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
		end
		if (pop) begin
			s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	a_buf_no_overflow : assert property (@(posedge clk) disable iff (reset)
		!in_ready |=> s_q.cnt == (AW+1)'(DEPTH) || $past(pop))
		else $error("buffer level moved while full without a pop");
endmodule : ppp_buffer
`default_nettype wire

/* File: rtl/ppp_port.sv */
/*
 * Parallel programming port: entry detection, command/address/data loads,
 * page buffers, flash/EEPROM/fuse/lock programming and read-back.
 * Assumes all pins asynchronous to clk; each passes two flip-flops first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppp_defs.svh"
module ppp_port #(
	parameter int         FLASH_AW  = 13,   // Word address bits, 13 on the larger part
	parameter int         MIN_BUSY  = 64,   // Least busy time in cycles
	parameter logic [7:0] SIG0      = 8'h5a, // Arbitrary identity value
	parameter logic [7:0] SIG1      = 8'h3c, // Arbitrary identity value
	parameter logic [7:0] SIG2      = 8'h66, // Arbitrary identity value
	parameter logic [7:0] CAL_BYTE  = 8'h80  // Oscillator calibration value
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// Programmer pins
	input  wire ppp_pkg::ppp_pins_s prog_pins,
	// Data bus drive
	output logic [7:0]              data_out,
	output logic                    data_oe,
	// Status
	output logic                    ready_busy_flag,
	output logic                    prog_mode_active
);
	import ppp_pkg::*;

	//------------------------------------------------------------
	// Sizes
	//------------------------------------------------------------
	localparam int FLASH_WORDS = 1 << FLASH_AW;
	localparam int PAGE_WORDS  = 1 << `PPP_FLASH_PAGE_BITS;
	localparam int EE_BYTES    = 1 << `PPP_EE_AW;
	localparam int EE_PAGE     = 1 << `PPP_EE_PAGE_BITS;
	ppp_state_s s_q, s_d;                       // State and next state
	logic [15:0] flash_mem [FLASH_WORDS];        // Program flash
	logic [7:0]  ee_mem [EE_BYTES];              // Data EEPROM
	logic [15:0] page_buf [PAGE_WORDS];          // Flash page buffer
	logic [7:0]  ee_buf [EE_PAGE];               // EEPROM page buffer
	logic                active;                 // In programming mode
	logic                lp_rise, ld_ev, wr_ev, pl_ev;
	logic [1:0]          xa;                     // Action bits
	logic                bs1, bs2;               // Byte selects
	logic [FLASH_AW-1:0] flash_addr;             // Loaded word address
	logic [`PPP_EE_AW-1:0] ee_addr;              // Loaded byte address
	logic                keep_ee;                // EEPROM keep fuse programmed
	logic                wtype;                  // Loaded command writes
	logic                push_valid, push_ready;
	ppp_item_s           push_item, pop_item;
	logic                pop_valid, pop_ready;
	logic                flash_we, ee_we;
	logic [FLASH_AW-1:0] flash_wa;
	logic [`PPP_EE_AW-1:0] ee_wa;
	logic [15:0]         flash_wd;
	logic [7:0]          ee_wd;
	logic [15:0]         op_len, op_last;
	logic [7:0]          rd_byte;

	//------------------------------------------------------------
	// Pin decoding
	//------------------------------------------------------------
	assign active  = (s_q.mode == MODE_ACTIVE);
	// Pulses of 250 ns span ten clocks, so edges are seen reliably
	assign lp_rise = s_q.sync2.load_pulse_input & ~s_q.prev.load_pulse_input;
	assign ld_ev   = active & lp_rise & ~s_q.busy;
	assign wr_ev   = active & ~s_q.sync2.wr_n & s_q.prev.wr_n;
	assign pl_ev   = active & s_q.sync2.page_latch_strobe & ~s_q.prev.page_latch_strobe;
	assign xa      = {s_q.sync2.xtal_action_bit1, s_q.sync2.xtal_action_bit0};
	assign bs1     = s_q.sync2.page_latch_strobe;
	assign bs2     = s_q.sync2.xtal_action_bit1;
	assign flash_addr = FLASH_AW'({s_q.addr_hi, s_q.addr_lo});
	assign ee_addr    = {s_q.addr_hi[0], s_q.addr_lo};
	assign keep_ee    = ~s_q.fuse_hi[`PPP_FUSE_KEEP_BIT];
	assign wtype = (s_q.cmd == `PPP_CMD_ERASE) | (s_q.cmd == `PPP_CMD_WFUSE)
		| (s_q.cmd == `PPP_CMD_WLOCK) | (s_q.cmd == `PPP_CMD_WFLASH)
		| (s_q.cmd == `PPP_CMD_WEE);

	//------------------------------------------------------------
	// Page latch path through the two-entry buffer
	//------------------------------------------------------------
	assign push_valid = s_q.latch_pend | (pl_ev & bs1 & ((s_q.cmd == `PPP_CMD_WFLASH)
		| (s_q.cmd == `PPP_CMD_WEE)));
	assign push_item.to_ee = (s_q.cmd == `PPP_CMD_WEE);
	assign push_item.idx   = s_q.addr_lo[5:0];
	assign push_item.word  = {s_q.data_hi, s_q.data_lo};
	assign pop_ready       = ~s_q.busy;

	ppp_buffer #(
		.W     ($bits(ppp_item_s)),
		.DEPTH (2)
	) u_buf (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_item),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_item)
	);
	//------------------------------------------------------------
	// Memory write ports driven by the running operation
	//------------------------------------------------------------
	assign flash_we = s_q.busy & (((s_q.op == OP_ERASE) & (s_q.cnt < 16'(FLASH_WORDS)))
		| ((s_q.op == OP_FLASH) & (s_q.cnt < 16'(PAGE_WORDS))));
	assign flash_wa = (s_q.op == OP_ERASE) ? s_q.cnt[FLASH_AW-1:0]
		: {flash_addr[FLASH_AW-1:`PPP_FLASH_PAGE_BITS], s_q.cnt[5:0]};
	assign flash_wd = (s_q.op == OP_ERASE) ? `PPP_ERASED_WORD : page_buf[s_q.cnt[5:0]];
	assign ee_we = s_q.busy & (((s_q.op == OP_ERASE) & ~keep_ee
		& (s_q.cnt < 16'(EE_BYTES))) | ((s_q.op == OP_EE) & (s_q.cnt < 16'(EE_PAGE))));
	assign ee_wa = (s_q.op == OP_ERASE) ? s_q.cnt[`PPP_EE_AW-1:0]
		: {ee_addr[`PPP_EE_AW-1:`PPP_EE_PAGE_BITS], s_q.cnt[1:0]};
	assign ee_wd = (s_q.op == OP_ERASE) ? `PPP_ERASED_BYTE : ee_buf[s_q.cnt[1:0]];

	// Length of the running operation
	always_comb begin
		unique case (s_q.op)
			OP_ERASE: op_len = 16'(((FLASH_WORDS > EE_BYTES) ? FLASH_WORDS : EE_BYTES) + 1);
			OP_FLASH: op_len = 16'(PAGE_WORDS);
			OP_EE:    op_len = 16'(EE_PAGE);
			default:  op_len = 16'h0001;
		endcase
		op_last = ((op_len > 16'(MIN_BUSY)) ? op_len : 16'(MIN_BUSY)) - 16'h0001;
	end

	//------------------------------------------------------------
	// Read-back byte selected by the loaded command
	//------------------------------------------------------------
	always_comb begin
		unique case (s_q.cmd)
			`PPP_CMD_RFLASH: rd_byte = bs1 ? flash_mem[flash_addr][15:8]
				: flash_mem[flash_addr][7:0];
			`PPP_CMD_REE:    rd_byte = ee_mem[ee_addr];
			`PPP_CMD_RSIG: begin
				if (bs1) begin
					rd_byte = CAL_BYTE;                                  // Calibration byte
				end else begin
					unique case (s_q.addr_lo[1:0])
						2'h0:    rd_byte = SIG0;
						2'h1:    rd_byte = SIG1;
						2'h2:    rd_byte = SIG2;
						default: rd_byte = 8'hff;
					endcase
				end
			end
			`PPP_CMD_RFUSE: begin
				unique case ({bs2, bs1})
					2'b00:   rd_byte = s_q.fuse_lo;
					2'b11:   rd_byte = s_q.fuse_hi;
					2'b10:   rd_byte = s_q.fuse_ext;
					default: rd_byte = s_q.lock;
				endcase
			end
			default: rd_byte = 8'h00;
		endcase
	end

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Two-stage synchroniser and edge history
		s_d.sync1 = prog_pins;
		s_d.sync2 = s_q.sync1;
		s_d.prev  = s_q.sync2;

		// Programming mode entry
		unique case (s_q.mode)
			MODE_OFF: begin
				if (~s_q.sync2.hv_reset && lp_rise && s_q.toggles != 3'h7) begin
					s_d.toggles = s_q.toggles + 3'h1;
				end
				if (s_q.sync2.hv_reset && ~s_q.prev.hv_reset) begin
					s_d.entry_cnt = '0;
					if (s_q.toggles >= 3'(`PPP_MIN_TOGGLES) && s_q.sync2.page_latch_strobe
						== 1'b0 && xa == 2'b00 && s_q.sync2.wr_n == 1'b0) begin
						s_d.mode = MODE_ARM;
					end else begin
						s_d.mode = MODE_FAIL;
					end
				end
			end
			MODE_ARM: begin
				if (~s_q.sync2.hv_reset) begin
					s_d.mode = MODE_OFF;
				end else if ({s_q.sync2.page_latch_strobe, xa, s_q.sync2.wr_n} != 4'h0) begin
					s_d.mode = MODE_FAIL;
				end else if (s_q.entry_cnt == 3'(`PPP_ENTRY_CYC - 1)) begin
					s_d.mode = MODE_ACTIVE;
				end else begin
					s_d.entry_cnt = s_q.entry_cnt + 3'h1;
				end
			end
			MODE_ACTIVE, MODE_FAIL: begin
				if (~s_q.sync2.hv_reset) begin
					s_d.mode    = MODE_OFF;
					s_d.toggles = '0;
				end
			end
		endcase

		// Loads on the load pulse; command and address persist
		if (ld_ev) begin
			unique case (xa)
				`PPP_XA_ADDR: begin
					if (bs1) s_d.addr_hi = s_q.sync2.data;
					else     s_d.addr_lo = s_q.sync2.data;
				end
				`PPP_XA_DATA: begin
					if (bs1) s_d.data_hi = s_q.sync2.data;
					else     s_d.data_lo = s_q.sync2.data;
				end
				`PPP_XA_CMD:  s_d.cmd = s_q.sync2.data;
				`PPP_XA_IDLE: ;
			endcase
		end

		// Page latch held pending while the buffer is full
		s_d.latch_pend = push_valid & ~push_ready;
		if (ld_ev && xa == `PPP_XA_CMD && s_q.sync2.data == `PPP_CMD_NOP) begin
			s_d.latch_pend = 1'b0;
		end

		// Start of a write-type operation on the write strobe
		if (wr_ev && ~s_q.busy && wtype) begin
			s_d.cnt  = '0;
			s_d.busy = 1'b1;
			unique case (s_q.cmd)
				`PPP_CMD_ERASE:  s_d.op = OP_ERASE;
				`PPP_CMD_WFLASH: s_d.op = OP_FLASH;
				`PPP_CMD_WEE:    s_d.op = OP_EE;
				`PPP_CMD_WLOCK:  s_d.op = OP_LOCK;
				default: s_d.op = bs2 ? OP_FUSE_EXT : (bs1 ? OP_FUSE_HI : OP_FUSE_LO);
			endcase
			// Locked memories and fuses refuse programming
			if (~s_q.lock[0] && s_q.cmd != `PPP_CMD_ERASE
				&& !(s_q.cmd == `PPP_CMD_WLOCK && s_q.lock[1])) begin
				s_d.busy = 1'b0;
				s_d.op   = OP_NONE;
			end
		end

		// Running operation; fuse and lock updates land at its end
		if (s_q.busy) begin
			s_d.cnt = s_q.cnt + 16'h0001;
			if (s_q.cnt == op_last) begin
				s_d.busy = 1'b0;
				s_d.op   = OP_NONE;
				unique case (s_q.op)
					OP_ERASE:    s_d.lock = `PPP_LOCK_RST;
					OP_FUSE_LO:  s_d.fuse_lo = s_q.data_lo;
					OP_FUSE_HI:  s_d.fuse_hi = s_q.data_lo;
					OP_FUSE_EXT: s_d.fuse_ext = s_q.data_lo;
					OP_LOCK:     s_d.lock = s_q.lock & s_q.data_lo;
					default: ;
				endcase
			end
		end

		// Outputs
		s_d.rdy  = ~s_d.busy & ~s_d.latch_pend;
		s_d.act  = (s_d.mode == MODE_ACTIVE);                              // Registered mode flag
		s_d.doe  = active & ~s_q.sync2.oe_n;
		s_d.dout = rd_byte;
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			s_q          <= '0;
			s_q.sync1.wr_n <= 1'b1;
			s_q.sync2.wr_n <= 1'b1;
			s_q.prev.wr_n  <= 1'b1;
			s_q.fuse_lo  <= `PPP_FUSE_LO_RST;
			s_q.fuse_hi  <= `PPP_FUSE_HI_RST;
			s_q.fuse_ext <= `PPP_FUSE_EXT_RST;
			s_q.lock     <= `PPP_LOCK_RST;
			s_q.rdy      <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	//------------------------------------------------------------
	// Memories and page buffers
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (flash_we) flash_mem[flash_wa] <= flash_wd;
		if (ee_we)    ee_mem[ee_wa] <= ee_wd;
		// Unlatched words must program as erased, so refill after every page
		if (reset || (s_q.busy && s_q.cnt == op_last && s_q.op inside {OP_FLASH, OP_EE})) begin
			page_buf <= '{default: `PPP_ERASED_WORD};
			ee_buf   <= '{default: `PPP_ERASED_BYTE};
		end else if (pop_valid && pop_ready) begin
			if (pop_item.to_ee) ee_buf[pop_item.idx[1:0]] <= pop_item.word[7:0];
			else                page_buf[pop_item.idx] <= pop_item.word;
		end
	end
	assign data_out         = s_q.dout;
	assign data_oe          = s_q.doe;
	assign ready_busy_flag  = s_q.rdy;
	assign prog_mode_active = s_q.act;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	a_bus_drive_oe : assert property (@(posedge clk) disable iff (reset)
		s_q.sync2.oe_n |=> !data_oe)
		else $error("data bus driven with output enable high");
	a_busy_flag_low : assert property (@(posedge clk) disable iff (reset)
		s_q.busy |-> !ready_busy_flag)
		else $error("ready flag high during an operation");
	a_cmd_kept : assert property (@(posedge clk) disable iff (reset)
		!(ld_ev && xa == `PPP_XA_CMD) |=> $stable(s_q.cmd))
		else $error("command changed without a command load");
	a_addr_hi_kept : assert property (@(posedge clk) disable iff (reset)
		!(ld_ev && xa == `PPP_XA_ADDR && bs1) |=> $stable(s_q.addr_hi))
		else $error("address high byte changed without a load");
	a_wr_ignored : assert property (@(posedge clk) disable iff (reset)
		(wr_ev && !wtype && !s_q.busy) |=> !s_q.busy)
		else $error("non-write command started an operation");
	a_erase_start : assert property (@(posedge clk) disable iff (reset)
		(wr_ev && !s_q.busy && s_q.cmd == `PPP_CMD_ERASE) |=> s_q.busy ##1 !ready_busy_flag)
		else $error("erase did not start on write strobe");
	a_ee_kept : assert property (@(posedge clk) disable iff (reset)
		(s_q.op == OP_ERASE && keep_ee) |-> !ee_we)
		else $error("EEPROM written during erase with keep fuse set");
	a_lock_last : assert property (@(posedge clk) disable iff (reset)
		(s_q.op == OP_ERASE && s_q.cnt < 16'(FLASH_WORDS)) |=> s_q.lock == $past(s_q.lock))
		else $error("lock bits released before flash erase finished");
	a_load_busy : assert property (@(posedge clk) disable iff (reset)
		(s_q.busy && lp_rise) |=> $stable(s_q.addr_lo) && $stable(s_q.data_lo))
		else $error("load accepted while busy");
endmodule : ppp_port
`default_nettype wire

/* File: verification/ppp_programmer.sv */
/*
 * Programmer model for the parallel programming port: slow strobes and loads.
 * Assumes the port's clk; pins change 1 ns after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ppp_programmer (
	// Clock and status
	input  wire logic               clk,
	input  wire logic               ready,
	// Pins and read-back
	output var  ppp_pkg::ppp_pins_s pins,
	input  wire logic [8:0]         rd_bus
);
	import ppp_pkg::*;
	// Idle pins until entry
	initial begin
		pins = '0;
		pins.oe_n = 1'b1;
		pins.wr_n = 1'b1;
	end
	// Let n edges pass, then settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Entry: six toggles in reset, entry pins 0000, held after high voltage
	task automatic enter();
		pins.wr_n = 1'b0;
		repeat (6) begin
			pins.load_pulse_input = 1'b1;
			tick(10);
			pins.load_pulse_input = 1'b0;
			tick(10);
		end
		tick(8);
		pins.hv_reset = 1'b1;
		tick(8);
		pins.wr_n = 1'b1;
		tick(2000);
	endtask : enter
	// One load, every phase 300 ns
	task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
		{pins.xtal_action_bit1, pins.xtal_action_bit0} = act;
		pins.page_latch_strobe = bs1;
		pins.data = d;
		tick(12);
		pins.load_pulse_input = 1'b1;
		tick(12);
		pins.load_pulse_input = 1'b0;
		tick(12);
	endtask : load
	// Page latch pulse with the high byte selected
	task automatic latch();
		{pins.xtal_action_bit1, pins.xtal_action_bit0} = 2'h3;
		pins.page_latch_strobe = 1'b0;
		tick(12);
		pins.page_latch_strobe = 1'b1;
		tick(12);
		pins.page_latch_strobe = 1'b0;
		tick(12);
	endtask : latch
	// Write strobe; reports the flag mid-pulse, then waits for ready
	task automatic strobe(output logic mid);
		pins.wr_n = 1'b0;
		tick(6);
		mid = ready;
		tick(6);
		pins.wr_n = 1'b1;
		for (int i = 0; i < 3000 && ready !== 1'b1; i++) tick(1);
	endtask : strobe
	// Read with selects; bus released, so drive the inverse of the last value
	task automatic read(input logic bs2, input logic bs1, output logic [8:0] q);
		pins.xtal_action_bit1 = bs2;
		pins.page_latch_strobe = bs1;
		pins.data = ~pins.data;
		pins.oe_n = 1'b0;
		tick(12);
		q = rd_bus;
		pins.oe_n = 1'b1;
		tick(12);
	endtask : read
endmodule : ppp_programmer
`default_nettype wire

/* File: verification/parallel_program_port_tb_top.sv */
/*
 * Self-checking bench of the parallel programming port.
 * Assumes ppp_pkg compiled first and ppp_defs.svh on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ppp_defs.svh"
module parallel_program_port_tb_top;
	import ppp_pkg::*;
	logic       clk;              // 40 MHz clock
	logic       reset;            // Synchronous reset
	ppp_pins_s  pins;             // Programmer pins
	logic [7:0] data_out;         // Read-back byte
	logic       data_oe;          // Bus drive
	logic       ready_busy_flag;  // Ready flag
	logic       prog_mode_active; // Mode flag
	logic       mid;              // Flag seen mid-strobe
	logic [8:0] q;                // Read result
	int         mismatches;
	int         check_count;
	int         cycles;
	localparam logic [7:0] SIG_TB = 8'h3e; // Arbitrary identity value
	// Short erase and busy counts
	ppp_port #(.FLASH_AW(8), .MIN_BUSY(4), .SIG0(SIG_TB)) ppp_port_i (.clk(clk), .reset(reset),
		.prog_pins(pins), .data_out(data_out), .data_oe(data_oe),
		.ready_busy_flag(ready_busy_flag), .prog_mode_active(prog_mode_active));
	ppp_programmer ppp_programmer_i (.clk(clk), .ready(ready_busy_flag), .pins(pins),
		.rd_bus({data_oe, data_out}));
	// Clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			complete_run();
		end
	end
	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Verdict
	task automatic complete_run();
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// Idle outputs after reset, then entry
	task automatic t_entry();
		check("ready", ready_busy_flag, 1'b1);
		check("oe", data_oe, 1'b0);
		ppp_programmer_i.enter();
		check("mode", prog_mode_active, 1'b1);
	endtask : t_entry
	// Default fuse and lock bytes over every select pair
	task automatic t_fuses();
		logic [7:0] exp [4];
		exp = '{`PPP_FUSE_LO_RST, `PPP_LOCK_RST, `PPP_FUSE_EXT_RST, `PPP_FUSE_HI_RST};
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_RFUSE);
		for (int i = 0; i < 4; i++) begin
			ppp_programmer_i.read(i[1], i[0], q);
			check("fuse", q, {1'b1, exp[i]});
		end
		check("oe off", data_oe, 1'b0);
	endtask : t_fuses
	// Erase goes busy, then the top EEPROM byte reads erased
	task automatic t_erase();
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_ERASE);
		ppp_programmer_i.strobe(mid);
		check("erase busy", mid, 1'b0);
		check("erase done", ready_busy_flag, 1'b1);
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b1, 8'h01);
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b0, 8'hff);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_REE);
		ppp_programmer_i.read(1'b0, 1'b0, q);
		check("ee erased", q, {1'b1, `PPP_ERASED_BYTE});
	endtask : t_erase
	// Page write of one word, refused strobe, read-back without reloads
	task automatic t_flash();
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_WFLASH);
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b0, 8'h45);
		ppp_programmer_i.load(`PPP_XA_DATA, 1'b0, 8'h34);
		ppp_programmer_i.load(`PPP_XA_DATA, 1'b1, 8'h12);
		ppp_programmer_i.latch();
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b1, 8'h00);
		ppp_programmer_i.strobe(mid);
		check("page busy", mid, 1'b0);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_NOP);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_RFLASH);
		ppp_programmer_i.strobe(mid);
		check("read strobe", mid, 1'b1);
		ppp_programmer_i.read(1'b0, 1'b0, q);
		check("word lo", q, 9'h134);
		ppp_programmer_i.read(1'b0, 1'b1, q);
		check("word hi", q, 9'h112);
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b0, 8'h44);
		ppp_programmer_i.read(1'b0, 1'b1, q);
		check("other word", q, 9'h1ff);
	endtask : t_flash
	// Keep fuse, EEPROM page, lock; erase keeps EEPROM and fuses, frees lock
	task automatic t_keep();
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_WFUSE);
		ppp_programmer_i.load(`PPP_XA_DATA, 1'b0, 8'hd7);
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b1, 8'h01);
		ppp_programmer_i.strobe(mid);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_WEE);
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b0, 8'hff);
		ppp_programmer_i.load(`PPP_XA_DATA, 1'b0, 8'h5c);
		ppp_programmer_i.latch();
		ppp_programmer_i.strobe(mid);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_WLOCK);
		ppp_programmer_i.load(`PPP_XA_DATA, 1'b0, 8'hfe);
		ppp_programmer_i.strobe(mid);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_RFUSE);
		ppp_programmer_i.read(1'b0, 1'b1, q);
		check("lock set", q, 9'h1fe);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_ERASE);
		ppp_programmer_i.strobe(mid);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_REE);
		ppp_programmer_i.read(1'b0, 1'b0, q);
		check("ee kept", q, 9'h15c);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_RFUSE);
		ppp_programmer_i.read(1'b0, 1'b1, q);
		check("lock freed", q, 9'h1ff);
		ppp_programmer_i.read(1'b1, 1'b1, q);
		check("fuse kept", q, 9'h1d7);
		ppp_programmer_i.load(`PPP_XA_CMD, 1'b0, `PPP_CMD_RSIG);
		ppp_programmer_i.load(`PPP_XA_ADDR, 1'b0, 8'h00);
		ppp_programmer_i.read(1'b0, 1'b0, q);
		check("signature", q, {1'b1, SIG_TB});
	endtask : t_keep
	// Main sequence
	initial begin
		reset = 1'b1;
		repeat (5) @(posedge clk);
		#1 reset = 1'b0;
		ppp_programmer_i.tick(2);
		t_entry();
		t_fuses();
		t_erase();
		t_flash();
		t_keep();
		complete_run();
	end
endmodule : parallel_program_port_tb_top
`default_nettype wire
